// *** core/sdl_map.svh ***
// register map, field positions and timing constants for the sample lock block
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH
`define SDL_ADDR_ACCEL_CFG 7'h03
`define SDL_ADDR_GYRO_CFG 7'h04
`define SDL_ADDR_ENABLE_CTRL 7'h08
`define SDL_ADDR_HOST_CMD 7'h0A
`define SDL_ADDR_CMD_ARG_LOW 7'h0B
`define SDL_ADDR_STATUS 7'h2D
`define SDL_ADDR_DATA_FIRST 7'h35
`define SDL_ADDR_ACCEL_Z_HIGH 7'h3A
`define SDL_ADDR_GYRO_Z_HIGH 7'h40
`define SDL_BIT_ACCEL_EN 0
`define SDL_BIT_GYRO_EN 1
`define SDL_BIT_SYNC 7
`define SDL_BIT_AVAIL 0
`define SDL_BIT_LOCKED 1
`define SDL_CMD_CLOCK_GATING 8'h12
`define SDL_CLK_PERIOD_NS 5
`define SDL_NS_PER_US 1000
`define SDL_RESET_BYTE 8'h00
`endif

// *** core/sdl_pkg.sv ***
// types for the sample lock block
package sdl_pkg;
   typedef struct packed {
      logic [15:0] gz;
      logic [15:0] gy;
      logic [15:0] gx;
      logic [15:0] az;
      logic [15:0] ay;
      logic [15:0] ax;
   } sdl_sample_s;
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [6:0] addr;
      logic [7:0] wrData;
   } sdl_reg_req_s;
   typedef enum logic [1:0] {SDL_IDLE, SDL_FREEZE, SDL_LOCKED} sdl_state_e;
endpackage

// *** core/sdl_sensor_data_lock.sv ***
// sample lock register bank with settle delay and clock gating control
`include "sdl_map.svh"
module sdl_sensor_data_lock #(
   parameter int CYC_PER_US = `SDL_NS_PER_US / `SDL_CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sdl_pkg::sdl_reg_req_s regReq,
   output logic [7:0] regRdData,
   input wire logic sampleValid,
   input wire sdl_pkg::sdl_sample_s sampleIn,
   output logic clkGatingOff,
   output logic sampleDropped
);
   localparam int DATA_BYTES = 12;

   // settle delay in microseconds per rate setting
   function automatic logic [8:0] lockDelayUs(input logic gyroOn, input logic [3:0] output_data_rate);
      logic [8:0] us;
      us = 9'd48;
      if (gyroOn)
      begin
         if (output_data_rate <= 4'h1) us = 9'd2;
         else if (output_data_rate == 4'h2) us = 9'd4;
         else if (output_data_rate == 4'h3) us = 9'd6;
         else us = 9'd12;
      end
      else
      begin
         case (output_data_rate)
            4'h3: us = 9'd6;
            4'h4: us = 9'd12;
            4'h5: us = 9'd24;
            4'hC: us = 9'd40;
            4'hD: us = 9'd100;
            4'hE: us = 9'd200;
            4'hF: us = 9'd270;
            default: us = 9'd48;
         endcase
      end
      return us;
   endfunction

   logic [7:0] accelCfg_r;
   logic [7:0] gyroCfg_r;
   logic [7:0] enableCtrl_r;
   logic [7:0] cmdArgLow_r;
   logic [95:0] dataReg_r;
   logic avail_r;
   logic locked_r;
   logic [16:0] settleCnt_r;
   logic [7:0] regRdData_r;
   logic clkGatingOff_r;
   logic sampleDropped_r;
   sdl_pkg::sdl_state_e state_r;
   sdl_pkg::sdl_state_e state_nxt;

   wire logic accelEn = enableCtrl_r[`SDL_BIT_ACCEL_EN];
   wire logic gyroEn = enableCtrl_r[`SDL_BIT_GYRO_EN];
   wire logic lockEn = enableCtrl_r[`SDL_BIT_SYNC] && (accelEn || gyroEn);
   wire logic [3:0] activeOdr = gyroEn ? gyroCfg_r[3:0] : accelCfg_r[3:0];
   wire logic [16:0] settleLoad = 17'(lockDelayUs(gyroEn, activeOdr) * CYC_PER_US - 1);
   wire logic statusRd = regReq.rdEn && (regReq.addr == `SDL_ADDR_STATUS);
   wire logic startFreeze = (state_r == sdl_pkg::SDL_IDLE) && statusRd && lockEn && avail_r;
   wire logic lastByteRd = regReq.rdEn &&
      ((gyroEn && regReq.addr == `SDL_ADDR_GYRO_Z_HIGH) ||
       (!gyroEn && accelEn && regReq.addr == `SDL_ADDR_ACCEL_Z_HIGH));
   wire logic lockRelease = (state_r != sdl_pkg::SDL_IDLE) && lastByteRd;
   // frozen sample blocks updates; release cycle lets a new one in
   wire logic accept = sampleValid && ((state_r == sdl_pkg::SDL_IDLE && !startFreeze) || lockRelease);
   wire logic cmdGating = regReq.wrEn && (regReq.addr == `SDL_ADDR_HOST_CMD) &&
      (regReq.wrData == `SDL_CMD_CLOCK_GATING);
   wire logic [6:0] dataIdx = regReq.addr - `SDL_ADDR_DATA_FIRST;
   wire logic inData = (regReq.addr >= `SDL_ADDR_DATA_FIRST) && (dataIdx < 7'(DATA_BYTES));
   wire logic [7:0] statusByte = 8'({locked_r, avail_r});
   wire logic [7:0] rdMux =
      (regReq.addr == `SDL_ADDR_ACCEL_CFG) ? accelCfg_r :
      (regReq.addr == `SDL_ADDR_GYRO_CFG) ? gyroCfg_r :
      (regReq.addr == `SDL_ADDR_ENABLE_CTRL) ? enableCtrl_r :
      (regReq.addr == `SDL_ADDR_CMD_ARG_LOW) ? cmdArgLow_r :
      (regReq.addr == `SDL_ADDR_STATUS) ? statusByte :
      inData ? dataReg_r[dataIdx[3:0] * 8 +: 8] : `SDL_RESET_BYTE;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         sdl_pkg::SDL_IDLE: if (startFreeze) state_nxt = sdl_pkg::SDL_FREEZE;
         sdl_pkg::SDL_FREEZE:
         begin
            if (lockRelease) state_nxt = sdl_pkg::SDL_IDLE;
            else if (settleCnt_r == 17'h0) state_nxt = sdl_pkg::SDL_LOCKED;
         end
         sdl_pkg::SDL_LOCKED: if (lockRelease) state_nxt = sdl_pkg::SDL_IDLE;
         default: state_nxt = sdl_pkg::SDL_IDLE;
      endcase
   end

   // rate and enable writes never disturb the lock state
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         accelCfg_r <= `SDL_RESET_BYTE;
         gyroCfg_r <= `SDL_RESET_BYTE;
         enableCtrl_r <= `SDL_RESET_BYTE;
         cmdArgLow_r <= `SDL_RESET_BYTE;
         clkGatingOff_r <= 1'b0;
      end
      else
      begin
         if (regReq.wrEn && regReq.addr == `SDL_ADDR_ACCEL_CFG) accelCfg_r <= regReq.wrData;
         if (regReq.wrEn && regReq.addr == `SDL_ADDR_GYRO_CFG) gyroCfg_r <= regReq.wrData;
         if (regReq.wrEn && regReq.addr == `SDL_ADDR_ENABLE_CTRL) enableCtrl_r <= regReq.wrData;
         if (regReq.wrEn && regReq.addr == `SDL_ADDR_CMD_ARG_LOW) cmdArgLow_r <= regReq.wrData;
         if (cmdGating) clkGatingOff_r <= cmdArgLow_r[0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_r <= sdl_pkg::SDL_IDLE;
         settleCnt_r <= 17'h0;
         avail_r <= 1'b0;
         locked_r <= 1'b0;
         dataReg_r <= 96'h0;
         regRdData_r <= `SDL_RESET_BYTE;
         sampleDropped_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         settleCnt_r <= startFreeze ? settleLoad : (settleCnt_r != 17'h0 ? settleCnt_r - 17'h1 : settleCnt_r);
         locked_r <= (state_nxt == sdl_pkg::SDL_LOCKED);
         if (accept) dataReg_r <= sampleIn;
         // new sample wins over the release clear
         if (accept) avail_r <= 1'b1;
         else if (lockRelease) avail_r <= 1'b0;
         sampleDropped_r <= sampleValid && !accept;
         regRdData_r <= regReq.rdEn ? rdMux : regRdData_r;
      end
   end

   assign regRdData = regRdData_r;
   assign clkGatingOff = clkGatingOff_r;
   assign sampleDropped = sampleDropped_r;

   property p_lock_gate;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_IDLE && !lockEn |=> state_r == sdl_pkg::SDL_IDLE;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("lock entered while locking disabled");

   property p_freeze_start;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_IDLE && statusRd && lockEn && avail_r |=> state_r == sdl_pkg::SDL_FREEZE && !locked_r;
   endproperty
   a_freeze_start: assert property (p_freeze_start) else $error("status read did not start freeze");

   property p_drop;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r != sdl_pkg::SDL_IDLE && !lockRelease |=> $stable(dataReg_r) && sampleDropped_r == $past(sampleValid);
   endproperty
   a_drop: assert property (p_drop) else $error("frozen sample was overwritten");

   property p_release;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r != sdl_pkg::SDL_IDLE && lastByteRd |=> state_r == sdl_pkg::SDL_IDLE && !locked_r;
   endproperty
   a_release: assert property (p_release) else $error("last byte read did not release lock");

   property p_status_freeze;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_FREEZE |-> avail_r && !locked_r;
   endproperty
   a_status_freeze: assert property (p_status_freeze) else $error("status wrong while freezing");

   property p_gyro_delay;
      @(posedge clk_sys) disable iff (!rst_n)
      startFreeze && gyroEn && gyroCfg_r[3:0] == 4'h2 |=> settleCnt_r == 17'(4 * CYC_PER_US - 1);
   endproperty
   a_gyro_delay: assert property (p_gyro_delay) else $error("gyro settle delay wrong");

   property p_accel_delay;
      @(posedge clk_sys) disable iff (!rst_n)
      startFreeze && !gyroEn && accelCfg_r[3:0] == 4'hF |=> settleCnt_r == 17'(270 * CYC_PER_US - 1);
   endproperty
   a_accel_delay: assert property (p_accel_delay) else $error("accel settle delay wrong");

   property p_odr_change;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_LOCKED && !lockRelease && regReq.wrEn |=> state_r == sdl_pkg::SDL_LOCKED && locked_r;
   endproperty
   a_odr_change: assert property (p_odr_change) else $error("register write broke the lock");

   property p_resume;
      @(posedge clk_sys) disable iff (!rst_n)
      lockRelease ##1 (sampleValid && !statusRd) |=> dataReg_r == $past(sampleIn) && avail_r;
   endproperty
   a_resume: assert property (p_resume) else $error("sample not taken after release");

   property p_settle_done;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_FREEZE && settleCnt_r == 17'h0 && !lockRelease |=>
         state_r == sdl_pkg::SDL_LOCKED && locked_r;
   endproperty
   a_settle_done: assert property (p_settle_done) else $error("lock not set after settle delay");

   property p_release_sample;
      @(posedge clk_sys) disable iff (!rst_n)
      lockRelease && sampleValid |=> avail_r && dataReg_r == $past(sampleIn) && !sampleDropped_r;
   endproperty
   a_release_sample: assert property (p_release_sample) else $error("sample in release cycle lost");

   property p_held_coherent;
      @(posedge clk_sys) disable iff (!rst_n)
      state_r == sdl_pkg::SDL_LOCKED && !lockRelease |=> state_r == sdl_pkg::SDL_LOCKED && $stable(dataReg_r);
   endproperty
   a_held_coherent: assert property (p_held_coherent) else $error("locked sample changed");

   c_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(locked_r));
   c_drop: cover property (@(posedge clk_sys) disable iff (!rst_n) sampleDropped_r && locked_r);
   c_release: cover property (@(posedge clk_sys) disable iff (!rst_n) locked_r ##1 !locked_r);
   c_gate: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(clkGatingOff_r));
endmodule

// *** verif/sdl_host_model.sv ***
// host processor model on the register port
module sdl_host_model (
   input wire logic clk_sys,
   input wire logic [7:0] regRdData,
   output sdl_pkg::sdl_reg_req_s regReq
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regReq = '0;
   // single write strobe
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
      @(negedge clk_sys);
      regReq.wrEn = 1'b0;
   endtask
   // single read, polls and data bytes
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
      @(negedge clk_sys);
      regReq.rdEn = 1'b0;
      d = regRdData;
   endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench for the sample lock block
`include "sdl_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sampleValid = 1'b0;
   sdl_pkg::sdl_sample_s sampleIn = '0;
   sdl_pkg::sdl_reg_req_s regReq;
   logic [7:0] regRdData;
   logic clkGatingOff;
   logic sampleDropped;
   logic [7:0] rdv;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   sdl_pkg::sdl_sample_s s1 = 96'h1B1A19181716151413121110;
   sdl_pkg::sdl_sample_s s2 = 96'h2B2A29282726252423222120;
   always #2.5 clk_sys = ~clk_sys;
   sdl_sensor_data_lock #(.CYC_PER_US(1)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
      .regRdData(regRdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
      .clkGatingOff(clkGatingOff), .sampleDropped(sampleDropped));
   sdl_host_model i_host (.clk_sys(clk_sys), .regRdData(regRdData), .regReq(regReq));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      i_host.rd(a, rdv);
      chk8($sformatf("reg %h", a), e, rdv);
   endtask
   task automatic send(input sdl_pkg::sdl_sample_s s, input logic dropExp);
      @(negedge clk_sys);
      sampleValid = 1'b1;
      sampleIn = s;
      @(negedge clk_sys);
      sampleValid = 1'b0;
      chk8("dropped", {7'h00, dropExp}, {7'h00, sampleDropped});
   endtask
   task automatic t_reset();
      rdc(`SDL_ADDR_STATUS, 8'h00);
      rdc(7'h7F, 8'h00);
      i_host.wr(`SDL_ADDR_STATUS, 8'hFF);
      rdc(`SDL_ADDR_STATUS, 8'h00);
      chk8("gating", 8'h00, {7'h00, clkGatingOff});
   endtask
   task automatic t_gating_on();
      i_host.wr(`SDL_ADDR_CMD_ARG_LOW, 8'h01);
      i_host.wr(`SDL_ADDR_HOST_CMD, `SDL_CMD_CLOCK_GATING);
      chk8("gating", 8'h01, {7'h00, clkGatingOff});
      rdc(`SDL_ADDR_CMD_ARG_LOW, 8'h01);
   endtask
   task automatic t_no_sync();
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h03);
      send(s2, 1'b0);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      send(s1, 1'b0);
      rdc(`SDL_ADDR_DATA_FIRST, s1.ax[7:0]);
   endtask
   task automatic t_gyro_lock();
      i_host.wr(`SDL_ADDR_GYRO_CFG, 8'h02);
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h83);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      send(s2, 1'b1);
      repeat (10) @(negedge clk_sys);
      rdc(`SDL_ADDR_STATUS, 8'h03);
      rdc(`SDL_ADDR_DATA_FIRST, s1.ax[7:0]);
      rdc(`SDL_ADDR_GYRO_Z_HIGH, s1.gz[15:8]);
      rdc(`SDL_ADDR_STATUS, 8'h00);
      send(s2, 1'b0);
      rdc(`SDL_ADDR_DATA_FIRST, s2.ax[7:0]);
   endtask
   task automatic t_accel_lock();
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h03);
      rdc(`SDL_ADDR_GYRO_Z_HIGH, s2.gz[15:8]);
      i_host.wr(`SDL_ADDR_ACCEL_CFG, 8'h0F);
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h81);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      repeat (250) @(negedge clk_sys);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      repeat (30) @(negedge clk_sys);
      rdc(`SDL_ADDR_STATUS, 8'h03);
      i_host.wr(`SDL_ADDR_ACCEL_CFG, 8'h0E);
      rdc(`SDL_ADDR_ACCEL_CFG, 8'h0E);
      rdc(`SDL_ADDR_GYRO_Z_HIGH, s2.gz[15:8]);
      rdc(`SDL_ADDR_STATUS, 8'h03);
      rdc(`SDL_ADDR_ACCEL_Z_HIGH, s2.az[15:8]);
      rdc(`SDL_ADDR_STATUS, 8'h00);
   endtask
   task automatic t_resume();
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h01);
      i_host.wr(`SDL_ADDR_ACCEL_CFG, 8'h03);
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h81);
      repeat (3) send(s2, 1'b0);
      send(s1, 1'b0);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      repeat (8) @(negedge clk_sys);
      rdc(`SDL_ADDR_STATUS, 8'h03);
      // sample in the release cycle is kept
      fork
         i_host.rd(`SDL_ADDR_ACCEL_Z_HIGH, rdv);
         send(s2, 1'b0);
      join
      chk8("release byte", s1.az[15:8], rdv);
      rdc(`SDL_ADDR_STATUS, 8'h01);
      // sample right after release updates outputs
      fork
         i_host.rd(`SDL_ADDR_ACCEL_Z_HIGH, rdv);
         begin
            @(negedge clk_sys);
            send(s1, 1'b0);
         end
      join
      chk8("release byte", s2.az[15:8], rdv);
      rdc(`SDL_ADDR_DATA_FIRST, s1.ax[7:0]);
   endtask
   task automatic t_exit();
      i_host.wr(`SDL_ADDR_ENABLE_CTRL, 8'h00);
      i_host.wr(`SDL_ADDR_CMD_ARG_LOW, 8'h00);
      i_host.wr(`SDL_ADDR_HOST_CMD, `SDL_CMD_CLOCK_GATING);
      chk8("gating", 8'h00, {7'h00, clkGatingOff});
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         end_sim();
      end
   end
   initial
   begin
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset();
      t_gating_on();
      t_no_sync();
      t_gyro_lock();
      t_accel_lock();
      t_resume();
      t_exit();
      end_sim();
   end
endmodule
